// ==== src/spp_port.sv ====
// Serial peripheral port, master or slave, byte wide, with APB registers.
// Assumes the pad ring resolves each pin from out and enable; disabled
// pins are left to the ordinary port logic (enables low).
// Function
// RQ1: Port disabled leaves serial pins to ordinary port control.
// RQ2: Enabled port keeps select pin quasi-bidirectional in both modes.
// RQ3: Master drives data-out and clock push-pull, data-in is input.
// RQ4: Slave drives its data-out only while select input is low.
// RQ5: Master driving select low still watches it for mode fault; the code skips the check while release_sel is set.
// RQ6: Polarity bit sets clock idle level only.
// RQ7: Phase 0 samples on first edge, phase 1 on second.
// RQ8: With phase 0 the master toggles select between bytes.
// RQ9: Phase 0 slave data write while selected flags write collision.
// RQ10: Phase 1 accepts back to back bytes with select held low.
// RQ11: Software disables port before changing polarity; settings match.
// RQ12: Transmit is single buffered; shifter loads only when idle.
// RQ13: Finished byte is copied to a separate read buffer.
// RQ14: Byte finishing before prior is read sets overrun, keeps old.
// RQ15: Most significant bit first, least first when order bit set.
// RQ16: Data write during transfer sets collision, transfer unchanged.
// RQ17: Write collision flag stays set until software clears it.
// RQ18: Transfer done flag sets when a byte completes.
// RQ19: Interrupt only with port and global interrupt enables set.
// RQ20: Transfer done flag stays set until software clears it.
// RQ21: Master seeing select low sets mode fault, clears master and enable.
// RQ22: Select used as output suppresses mode fault, flag stays clear.
// RQ23: Master bit set selects master, cleared selects slave.
// RQ24: Master data write starts a byte; slave never starts itself.
// RQ25: Baud field divides clock by 8, 32, 128 or 256.
// RQ26: Select output goes low per transfer and high while idle.
// RQ27: Slave aborts partial byte when select rises mid transfer.
`timescale 1ns/1ps

module spp_port
  import spp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire spp_pins_t   pin_i,
  output spp_pins_t        pin_o,
  output spp_pins_t        pin_oe,
  output logic             irq
);

  spp_regs_t r, n;

  // Half period of the serial clock for a baud selection
  function automatic logic [7:0] half_of(input logic [1:0] sel);
    unique case (sel)
      2'b00: half_of = SPP_HALF_D8;
      2'b01: half_of = SPP_HALF_D32;
      2'b10: half_of = SPP_HALF_D128;
      2'b11: half_of = SPP_HALF_D256;
    endcase
  endfunction

  // Next bit to put on the line for the chosen order
  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    out_bit = lsb ? s[0] : s[7];
  endfunction

  // Shift a received bit in from the side opposite the outgoing one
  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  logic acc;
  logic wr_ev;
  logic rd_ev;
  logic en;
  logic mst;
  logic pol;
  logic pha;
  logic lsb;
  logic sel_out;
  logic ss_in;
  logic sck_in;
  logic lead_e;
  logic trail_e;
  logic samp_e;
  logic shft_e;
  logic rx_bit;
  logic byte_end;
  logic [7:0] rx_byte;

  assign acc     = psel && penable;
  assign wr_ev   = acc && pwrite;
  assign rd_ev   = acc && !pwrite;
  assign en      = r.ctrl[SPP_C_ENABLE];
  assign mst     = r.ctrl[SPP_C_MASTER];
  assign pol     = r.ctrl[SPP_C_POL];
  assign pha     = r.ctrl[SPP_C_PHASE];
  assign lsb     = r.ctrl[SPP_C_LSB];
  assign sel_out = r.release_sel && r.ctrl[SPP_C_SELECT_OUTPUT_ENABLE];
  // Only the second stage of each synchroniser is read
  assign ss_in   = r.sync2.ss_n;
  assign sck_in  = r.sync2.sclk;

  always_comb begin
    n = r;
    n.sync1  = pin_i;
    n.sync2  = r.sync1;
    n.pready = 1'b0;
    lead_e   = 1'b0;
    trail_e  = 1'b0;
    byte_end = 1'b0;
    rx_bit   = mst ? r.sync2.miso : r.sync2.mosi;

    // Master clock divider and edge generation [RQ25]
    if (mst && r.state == SPP_RUN) begin
      if (r.div == 8'h01) begin
        n.div  = half_of(r.ctrl[SPP_C_BAUD0 +: 2]);
        n.sclk = ~r.sclk;
        lead_e  = ~r.edges[0];
        trail_e = r.edges[0];
      end else begin
        n.div = r.div - 8'h01;
      end
    end else if (mst && r.state == SPP_TAIL) begin
      // Select stays low one more half period so the far side takes its
      // last bit before the frame closes; closing on the edge races it
      if (r.div == 8'h01) begin
        n.state = SPP_IDLE;
      end else begin
        n.div = r.div - 8'h01;
      end
    end else if (!mst) begin
      // Slave edges come from the synchronised pin; polarity folds out [RQ6]
      n.sclk_q = sck_in;
      lead_e   = (r.state == SPP_RUN) && (sck_in ^ pol) && !(r.sclk_q ^ pol);
      trail_e  = (r.state == SPP_RUN) && !(sck_in ^ pol) && (r.sclk_q ^ pol);
    end

    // Phase 0 samples on the leading edge, phase 1 on the trailing [RQ7]
    samp_e = pha ? trail_e : lead_e;
    shft_e = pha ? lead_e : trail_e;
    rx_byte = shift_in(r.shift, lsb, rx_bit);
    if (samp_e) begin
      n.shift = rx_byte;
    end
    // Outgoing bit moves only on the shift edge, so it stands steady at the
    // far side's sampling edge instead of changing with it [RQ7]
    if (shft_e) begin
      n.tx_hold = out_bit(r.shift, lsb);
    end
    if (lead_e || trail_e) begin
      n.edges = r.edges + 4'h1;
      byte_end = (r.edges == SPP_EDGES);
    end

    // Slave select handling: start on select low, abort on high [RQ27]
    if (en && !mst) begin
      if (r.state == SPP_IDLE && !ss_in) begin
        n.state = SPP_RUN;
        n.edges = 4'h0;
        n.sclk_q = pol;
        n.tx_hold = out_bit(r.shift, lsb);
      end else if (r.state != SPP_IDLE && ss_in) begin
        n.state = SPP_IDLE;
      end
    end

    // Byte finished: hand to read buffer or flag overrun [RQ13] [RQ14]
    if (byte_end) begin
      n.done  = 1'b1;                                   // [RQ18]
      n.edges = 4'h0;
      if (r.done) begin
        n.ovr = 1'b1;                                   // [RQ14]
      end else begin
        n.rbuf = samp_e ? rx_byte : r.shift;            // [RQ13]
      end
      // Phase 1 slave stays ready for the next byte under a held select [RQ10]
      if (mst) begin
        n.state = SPP_TAIL;
      end else if (!pha) begin
        n.state = SPP_IDLE;
      end
      n.sclk = pol;
    end

    // Mode fault while the select pin is not released and the master role is set [RQ21] [RQ22]
    if (en && mst && !r.release_sel && !ss_in) begin
      n.mode_fault_flag = 1'b1;
      n.ctrl[SPP_C_MASTER] = 1'b0;
      n.ctrl[SPP_C_ENABLE] = 1'b0;
      n.state = SPP_IDLE;
    end
    if (r.release_sel) begin
      n.mode_fault_flag = 1'b0;                                    // [RQ22]
    end

    // APB access, taken in the first access cycle, answered with pready one cycle later
    n.prdata = 32'h0000_0000;
    if (acc && !r.pready) begin
      n.pready = 1'b1;
    end
    if (wr_ev && !r.pready) begin
      unique case (paddr)
        SPP_CTRL_OFF: n.ctrl = pwdata[8:0];
        SPP_STAT_OFF: begin
          // Writing 1 clears a flag; a same-cycle set wins [RQ17] [RQ20]
          // The set terms are the events themselves, so they win even when
          // the flag is already up as software clears it
          n.done = (r.done & ~pwdata[SPP_S_DONE]) | byte_end;
          n.write_collision_flag = r.write_collision_flag & ~pwdata[SPP_S_WRITE_COLLISION_FLAG];
          n.ovr  = (r.ovr & ~pwdata[SPP_S_OVR]) | (byte_end & r.done);
          n.mode_fault_flag = (r.mode_fault_flag & ~pwdata[SPP_S_MODE_FAULT_FLAG]) | (en & mst & ~r.release_sel & ~ss_in);
          n.release_sel = pwdata[SPP_S_REL];
        end
        SPP_DATA_OFF: begin
          // Busy or selected phase 0 slave: refuse and flag [RQ16] [RQ9] [RQ12]
          if (r.state != SPP_IDLE || (!mst && !pha && !ss_in && en)) begin
            n.write_collision_flag = 1'b1;
          end else begin
            n.shift   = pwdata[7:0];
            n.tx_hold = out_bit(pwdata[7:0], lsb);   // First bit before the first edge
            if (en && mst) begin
              // Master write starts a byte; slave only loads [RQ24] [RQ23]
              n.state = SPP_RUN;
              n.edges = 4'h0;
              n.div   = half_of(r.ctrl[SPP_C_BAUD0 +: 2]);
              n.sclk  = pol;
            end
          end
        end
        SPP_GIE_OFF: n.gie = pwdata[0];
        default: ;
      endcase
    end
    if (rd_ev && !r.pready) begin
      unique case (paddr)
        SPP_CTRL_OFF: n.prdata = {23'h0, r.ctrl};
        SPP_STAT_OFF: n.prdata = {24'h0, r.done, r.write_collision_flag, r.ovr, r.mode_fault_flag,
                                  r.release_sel, 2'b00, r.state != SPP_IDLE};
        SPP_DATA_OFF: n.prdata = {24'h0, r.rbuf};
        SPP_GIE_OFF:  n.prdata = {31'h0, r.gie};
        SPP_PIN_OFF:  n.prdata = {28'h0, r.sync2.sclk, r.sync2.mosi,
                                  r.sync2.miso, r.sync2.ss_n};
        default:      n.prdata = 32'h0000_0000;
      endcase
    end

    // Pin drive; everything released while disabled [RQ1]
    n.pin_o  = '0;
    n.pin_oe = '0;
    if (n.ctrl[SPP_C_ENABLE]) begin
      if (n.ctrl[SPP_C_MASTER]) begin
        // Clock and data out push-pull, data in sampled [RQ3]
        n.pin_oe.sclk = 1'b1;
        // Idle clock follows the polarity bit at once, so a new setting
        // never leaves the previous idle level on the line [RQ6]
        n.pin_o.sclk  = (n.state == SPP_RUN) ? n.sclk : n.ctrl[SPP_C_POL];
        n.pin_oe.mosi = 1'b1;
        n.pin_o.mosi  = n.tx_hold;   // [RQ15]
        // Select as quasi output: low per byte, high when idle [RQ26] [RQ2] [RQ5]
        if (n.release_sel && n.ctrl[SPP_C_SELECT_OUTPUT_ENABLE]) begin
          n.pin_o.ss_n  = (n.state == SPP_IDLE);
          n.pin_oe.ss_n = (n.state != SPP_IDLE);
        end
      end else if (!ss_in) begin
        // Slave answers only while selected [RQ4]
        n.pin_oe.miso = 1'b1;
        n.pin_o.miso  = n.tx_hold;   // [RQ15]
      end
    end

    // Interrupt needs both enables [RQ19]
    n.irq = n.ctrl[SPP_C_IRQEN] && n.gie && (n.done || n.mode_fault_flag);
  end

  // State register; reset loads constants only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r        <= '0;
      r.ctrl   <= SPP_CTRL_RST;
      r.rbuf   <= SPP_DATA_RST;
      r.state  <= SPP_IDLE;
      r.sync1  <= '1;
      r.sync2  <= '1;
    end else begin
      r <= n;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = 1'b0;
  assign pin_o   = r.pin_o;
  assign pin_oe  = r.pin_oe;
  assign irq     = r.irq;

endmodule

// ==== src/spp_pkg.sv ====
// Package for the serial peripheral port: register map, field positions,
// reset values, divider figures and the carrier structs.
// Assumes a 32-bit APB slave with one register per aligned word.
package spp_pkg;

  // Register byte offsets
  localparam logic [7:0] SPP_CTRL_OFF   = 8'h00;  // serial_control_reg
  localparam logic [7:0] SPP_STAT_OFF   = 8'h04;  // serial_status_reg
  localparam logic [7:0] SPP_DATA_OFF   = 8'h08;  // serial_data_reg
  localparam logic [7:0] SPP_GIE_OFF    = 8'h0C;  // global_irq_enable
  localparam logic [7:0] SPP_PIN_OFF    = 8'h10;  // pin levels

  // Control field positions
  localparam int SPP_C_BAUD0   = 0;  // baud_divider_select [1:0]
  localparam int SPP_C_PHASE   = 2;  // clock_sample_phase
  localparam int SPP_C_POL     = 3;  // clock_idle_polarity
  localparam int SPP_C_MASTER  = 4;  // master_select_bit
  localparam int SPP_C_LSB     = 5;  // bit_order_select
  localparam int SPP_C_ENABLE  = 6;  // port_enable_bit
  localparam int SPP_C_IRQEN   = 7;  // port_irq_enable
  localparam int SPP_C_SELECT_OUTPUT_ENABLE    = 8;  // select_output_enable

  // Status field positions
  localparam int SPP_S_DONE    = 7;  // transfer_done_flag
  localparam int SPP_S_WRITE_COLLISION_FLAG    = 6;  // write_collision_flag
  localparam int SPP_S_OVR     = 5;  // receive_overrun_flag
  localparam int SPP_S_MODE_FAULT_FLAG    = 4;  // mode_fault_flag
  localparam int SPP_S_REL     = 3;  // select_pin_release
  localparam int SPP_S_BUSY    = 0;  // transfer in progress

  localparam logic [8:0] SPP_CTRL_RST  = 9'h000;
  localparam logic [7:0] SPP_DATA_RST  = 8'h00;

  // Divider half periods in ref_clk cycles for divide by 8, 32, 128, 256
  localparam logic [7:0] SPP_HALF_D8   = 8'h04;
  localparam logic [7:0] SPP_HALF_D32  = 8'h10;
  localparam logic [7:0] SPP_HALF_D128 = 8'h40;
  localparam logic [7:0] SPP_HALF_D256 = 8'h80;
  localparam logic [3:0] SPP_EDGES     = 4'hF;  // Last of 16 clock edges per byte

  typedef enum logic [1:0] {
    SPP_IDLE = 2'b00,
    SPP_RUN  = 2'b01,
    SPP_TAIL = 2'b10   // Master holds select for a half period after the last edge
  } spp_state_t;

  // Pin carrier: input, output and output enable per pin
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
    logic ss_n;
  } spp_pins_t;

  // Whole state of the port
  typedef struct packed {
    spp_state_t state;
    logic [8:0] ctrl;
    logic       release_sel;
    logic       gie;
    logic       done;
    logic       write_collision_flag;
    logic       ovr;
    logic       mode_fault_flag;
    logic [7:0] shift;
    logic [7:0] rbuf;
    logic [7:0] div;
    logic [3:0] edges;
    logic       sclk;
    logic       sclk_q;
    logic       tx_hold;
    spp_pins_t  sync1;
    spp_pins_t  sync2;
    spp_pins_t  pin_o;
    spp_pins_t  pin_oe;
    logic       pready;
    logic [31:0] prdata;
    logic       irq;
  } spp_regs_t;

endpackage

// ==== sim/spp_port_properties.sv ====
// Checker for the serial port: watches the APB, pad and irq ports only.
// Assumes writes land at the first access edge, as the design takes them.
`timescale 1ns/1ps
module spp_port_properties
  import spp_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire spp_pins_t   pin_i,
  input wire spp_pins_t   pin_o,
  input wire spp_pins_t   pin_oe,
  input wire logic        irq
);
  logic [8:0] ctrl_m;
  logic       gie_m;
  logic       rel_m;
  logic       wr;
  assign wr = psel && penable && !pready && pwrite;
  // Mirror of what software wrote; hardware clears are not tracked
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_m <= 9'h000;
      gie_m  <= 1'b0;
      rel_m  <= 1'b0;
    end else if (wr) begin
      if (paddr == SPP_CTRL_OFF) ctrl_m <= pwdata[8:0];
      if (paddr == SPP_GIE_OFF) gie_m <= pwdata[0];
      if (paddr == SPP_STAT_OFF) rel_m <= pwdata[SPP_S_REL];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_off_pins_idle: assert property (
    !ctrl_m[SPP_C_ENABLE] |-> pin_oe == 4'h0) else $error("pins driven while port off");
  a_master_pins: assert property (
    pin_oe.sclk |-> pin_oe.mosi && !pin_oe.miso) else $error("master pin directions wrong");
  a_slave_miso_off: assert property (
    pin_i.ss_n [*5] |-> !pin_oe.miso) else $error("data-out driven while deselected");
  a_idle_level: assert property (
    (rel_m && ctrl_m[SPP_C_SELECT_OUTPUT_ENABLE] && !pin_oe.ss_n && pin_oe.sclk) [*3]
    |-> pin_o.sclk == ctrl_m[SPP_C_POL]) else $error("clock idle level differs from polarity");
  a_run_selects: assert property (
    rel_m && ctrl_m[SPP_C_SELECT_OUTPUT_ENABLE] && pin_oe.sclk && $past(pin_oe.sclk) && $changed(pin_o.sclk)
    |-> pin_oe.ss_n && !pin_o.ss_n) else $error("clock toggles while select high");
  a_gated_irq: assert property (
    irq |-> (gie_m && ctrl_m[SPP_C_IRQEN]) || wr) else $error("irq without both enables");
  a_done_irq: assert property (
    rel_m && ctrl_m[SPP_C_SELECT_OUTPUT_ENABLE] && $fell(pin_oe.ss_n) && gie_m
    && ctrl_m[SPP_C_IRQEN] |-> ##[0:8] irq) else $error("no irq after byte end");
  a_fault_stops: assert property (
    !ctrl_m[SPP_C_SELECT_OUTPUT_ENABLE] && !rel_m && ctrl_m[SPP_C_MASTER] && pin_oe.sclk && !pin_i.ss_n
    |-> ##[1:8] !pin_oe.sclk) else $error("mode fault left drivers on");
  a_no_fault_out: assert property (
    rel_m && ctrl_m[SPP_C_MASTER] && pin_oe.sclk && !pin_i.ss_n |=> pin_oe.sclk)
    else $error("fault taken with select as output");
  c_fault: cover property (ctrl_m[SPP_C_MASTER] && !rel_m && !pin_i.ss_n);
  c_irq: cover property (irq);
  c_frame: cover property ($fell(pin_o.ss_n));
endmodule

// ==== sim/spp_slave_model.sv ====
// Model serial slave: shifts in what the master sends, shifts out tx.
// Assumes master and slave agree on phase; polarity only moves edge sense.
`timescale 1ns/1ps
module spp_slave_model (
  input  wire logic       sclk,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       clock_sample_phase,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  int e = 0;
  int idx;
  initial rx = 8'h00;
  // Edge count restarts whenever the select is released
  always @(posedge ss_n) e = 0;
  // Odd edges sample with phase 0, even edges with phase 1
  always @(sclk) begin
    if (ss_n === 1'b0) begin
      e = e + 1;
      if (e[0] != clock_sample_phase) rx = {rx[6:0], mosi};
    end
  end
  // Released line floats to the pull-up level, so no stale bit lingers
  always_comb begin
    idx = clock_sample_phase ? (e == 0 ? 0 : (e - 1) / 2) : e / 2;
    if (idx > 7) idx = 7;
    miso = ss_n ? 1'b1 : tx[7 - idx];
  end
endmodule

// ==== sim/serial_peripheral_port_tb.sv ====
// Testbench for the serial port as bus master and as slave, with a model slave.
// Assumes pready comes one cycle into the access phase, as handed over.
`timescale 1ns/1ps
module serial_peripheral_port_tb
  import spp_pkg::*;
;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic        ss_low, clock_sample_phase, sl_miso;
  logic [7:0]  paddr, sl_tx, sl_rx;
  logic [31:0] pwdata, prdata, rd;
  spp_pins_t   pin_i, pin_o, pin_oe;
  int          n_mismatch, comparisons, edges, lowc;
  // Pads: undriven clock, data-out and select float high, data-in takes the slave model; the bench can pull select low
  assign pin_i = {pin_oe.sclk ? pin_o.sclk : 1'b1, pin_oe.mosi ? pin_o.mosi : 1'b1,
                  pin_oe.miso ? pin_o.miso : sl_miso,
                  ~ss_low & (pin_oe.ss_n ? pin_o.ss_n : 1'b1)};
  spp_port spp_port_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .irq(irq));
  spp_slave_model spp_slave_model_i (.sclk(pin_i.sclk), .ss_n(pin_i.ss_n),
    .mosi(pin_i.mosi), .clock_sample_phase(clock_sample_phase), .tx(sl_tx), .miso(sl_miso), .rx(sl_rx));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Frame measurements: clock edges and select-low span
  always @(pin_i.sclk) if (pin_i.ss_n === 1'b0) edges++;
  always @(posedge ref_clk) if (pin_i.ss_n === 1'b0) lowc <= lowc + 1;
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    if (pready !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    check("slave error", pslverr, 0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] order(input logic [7:0] b, input logic lsb);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[i] = b[7-i];
    return lsb ? r : b;
  endfunction
  // Start a byte, collide once mid-byte, poll until idle
  task automatic xfer(input logic [7:0] tx, input logic [7:0] st);
    int k;
    sl_tx = st;
    edges = 0;
    lowc = 0;
    apb(1'b1, SPP_DATA_OFF, {24'h0, tx});
    apb(1'b1, SPP_DATA_OFF, 32'h0000005A);
    k = 0;
    do begin
      apb(1'b0, SPP_STAT_OFF, 32'h0);
      k++;
    end while (rd[SPP_S_BUSY] !== 1'b0 && k < 1000);
    if (rd[SPP_S_BUSY] !== 1'b0) begin
      n_mismatch++;
      conclude();
    end
    check("select released", pin_i.ss_n, 1);
  endtask
  initial begin
    logic [7:0] tx, st, halfs [4];
    logic [8:0] cfg;
    int h;
    halfs = '{SPP_HALF_D8, SPP_HALF_D32, SPP_HALF_D128, SPP_HALF_D256};
    {psel, penable, pwrite, paddr, pwdata, ss_low, clock_sample_phase, sl_tx, rst_n} = '0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(32'h6687B9F8));
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, SPP_CTRL_OFF, 32'h0);
    check("ctrl reset", rd, {23'h0, SPP_CTRL_RST});
    apb(1'b0, SPP_DATA_OFF, 32'h0);
    check("data reset", rd, {24'h0, SPP_DATA_RST});
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped read", rd, 32'h0);
    apb(1'b1, SPP_GIE_OFF, 32'h1);
    // Every phase/polarity/order combination, every divider
    for (int i = 0; i < 8; i++) begin
      tx = (i == 0) ? 8'h80 : (i == 7) ? 8'hFF : 8'($urandom);
      st = (i == 0) ? 8'h01 : 8'($urandom);
      cfg = {3'h7, i[2], 1'b1, i[1], i[0], 2'((i + i / 4) % 4)};
      h = halfs[cfg[1:0]];
      clock_sample_phase = i[0];
      apb(1'b1, SPP_CTRL_OFF, {23'h0, cfg & 9'h1BF});
      apb(1'b1, SPP_STAT_OFF, 32'hF8);
      apb(1'b1, SPP_CTRL_OFF, {23'h0, cfg});
      xfer(tx, st);
      check("edges", edges, 16);
      check("slave rx", sl_rx, order(tx, i[2]));
      check("select span", lowc >= 16 * h && lowc <= 18 * h + 8, 1);
      check("status", rd[7:0], 8'hC8);
      check("irq", irq, 1);
      apb(1'b0, SPP_DATA_OFF, 32'h0);
      check("rx data", rd[7:0], order(st, i[2]));
      apb(1'b1, SPP_STAT_OFF, 32'hF8);
    end
    xfer(8'h3C, 8'h5A);
    xfer(8'hC3, 8'hA5);
    check("overrun status", rd[7:0], 8'hE8);
    apb(1'b0, SPP_DATA_OFF, 32'h0);
    check("kept byte", rd[7:0], order(8'h5A, 1'b1));
    apb(1'b1, SPP_GIE_OFF, 32'h0);
    repeat (2) @(posedge ref_clk);
    check("masked irq", irq, 0);
    apb(1'b1, SPP_GIE_OFF, 32'h1);
    apb(1'b1, SPP_STAT_OFF, 32'hF0);
    apb(1'b1, SPP_CTRL_OFF, 32'h0D0);
    ss_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    ss_low <= 1'b0;
    apb(1'b0, SPP_STAT_OFF, 32'h0);
    check("mode fault", rd[SPP_S_MODE_FAULT_FLAG], 1);
    apb(1'b0, SPP_CTRL_OFF, 32'h0);
    check("ctrl after fault", rd, 32'h080);
    check("fault irq", irq, 1);
    apb(1'b1, SPP_STAT_OFF, 32'h18);
    apb(1'b1, SPP_CTRL_OFF, 32'h0D0);
    ss_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, SPP_STAT_OFF, 32'h0);
    ss_low <= 1'b0;
    check("no fault", rd[SPP_S_MODE_FAULT_FLAG], 0);
    apb(1'b0, SPP_CTRL_OFF, 32'h0);
    check("ctrl kept", rd, 32'h0D0);
    // Selected slave answers on data-out, refuses a data write, aborts on release
    apb(1'b1, SPP_STAT_OFF, 32'hF0);
    apb(1'b1, SPP_CTRL_OFF, 32'h040);
    ss_low <= 1'b1;
    repeat (8) @(posedge ref_clk);
    apb(1'b1, SPP_DATA_OFF, 32'h00000033);
    apb(1'b0, SPP_STAT_OFF, 32'h0);
    check("slave write_collision_flag", rd[SPP_S_WRITE_COLLISION_FLAG], 1);
    check("slave busy", rd[SPP_S_BUSY], 1);
    check("slave miso on", pin_oe.miso, 1);
    ss_low <= 1'b0;
    repeat (8) @(posedge ref_clk);
    apb(1'b0, SPP_STAT_OFF, 32'h0);
    check("slave aborted", rd[SPP_S_BUSY], 0);
    check("slave miso off", pin_oe.miso, 0);
    conclude();
  end
endmodule
bind spp_port spp_port_properties spp_port_properties_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .irq(irq));
